// ### core/pg_pkg.sv
// ==========================================================================
// shared constants for the protected region guard
package pg_pkg;

  // ========================================================================
  // device register map (byte offsets on the guard's register port)
  localparam int          PG_ADDR_W        = 12;
  localparam logic [11:0] PG_PROT_EN_OFF   = 12'h064;
  localparam logic [11:0] PG_LOW_BASE_OFF  = 12'h068;
  localparam logic [11:0] PG_LOW_LIMIT_OFF = 12'h06C;

  // ========================================================================
  // field positions and values after reset
  localparam int          PG_EN_BIT        = 31;
  localparam int          PG_STS_BIT       = 0;
  localparam logic [31:0] PG_LOW_BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] PG_LOW_LIMIT_RST = 32'h0000_0000;
  localparam logic        PG_EN_RST        = 1'b0;

  // ========================================================================
  // controller user registers (byte offsets on its plain port)
  localparam logic [7:0]  PG_H_FWD_ADDR_OFF  = 8'h00;
  localparam logic [7:0]  PG_H_FWD_DATA_OFF  = 8'h04;
  localparam logic [7:0]  PG_H_FWD_CMD_OFF   = 8'h08;
  localparam logic [7:0]  PG_H_FWD_RDATA_OFF = 8'h0C;
  localparam logic [7:0]  PG_H_DMA_ADDR_OFF  = 8'h10;
  localparam logic [7:0]  PG_H_DMA_CMD_OFF   = 8'h14;
  localparam logic [7:0]  PG_H_STATUS_OFF    = 8'h18;

  // controller command and status bit positions
  localparam int PG_H_CMD_WR_BIT  = 0;
  localparam int PG_H_CMD_RD_BIT  = 1;
  localparam int PG_H_ST_DMA_DONE = 0;
  localparam int PG_H_ST_DMA_BLK  = 1;
  localparam int PG_H_ST_REFUSED  = 2;
  localparam int PG_H_ST_GUARD    = 3;
  localparam int PG_H_ST_DMA_PEND = 4;
  localparam int PG_H_ST_FWD_DONE = 5;

  // ========================================================================
  // kinds of memory request seen by the guard
  typedef enum logic [1:0] {
    PG_REQ_PASS,
    PG_REQ_REMAP,
    PG_REQ_CACHE,
    PG_REQ_FETCH
  } pg_req_t;

  // guard sequencing states
  typedef enum logic [1:0] {
    PG_ST_OFF,
    PG_ST_DRAIN,
    PG_ST_ON,
    PG_ST_STOP
  } pg_state_t;

endpackage

// ### core/pg_link_if.sv
`timescale 1ns/1ns
// ==========================================================================
// link between the guard and the request path / programming controller
interface pg_link_if;
  import pg_pkg::*;

  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        dma_valid;
  logic [31:0] dma_addr;
  pg_req_t     dma_kind;
  logic        resp_valid;
  logic        resp_block;
  logic        drain_req;
  logic        drain_done;
  logic        prot_status;

  modport dev (
    input  reg_addr, reg_wdata, reg_wr, reg_rd, dma_valid, dma_addr, dma_kind, drain_done,
    output reg_rdata, resp_valid, resp_block, drain_req, prot_status
  );

  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, dma_valid, dma_addr, dma_kind, drain_done,
    input  reg_rdata, resp_valid, resp_block, drain_req, prot_status
  );

endinterface

// ### core/pg_guard_dev.sv
`timescale 1ns/1ns
// ==========================================================================
// guard end: register file, region decode, request blocking, sequencing

// Summary of operation
// R1 - bit 31 of control enables protected regions
// R2 - block io requests hitting region when enabled
// R3 - own structure fetches always bypass the check
// R4 - blocked requests never raise remapping faults
// R5 - read-only bit 0 shows regions in force
// R6 - drain in-flight translated requests before status
// R7 - coherent cache link accesses are not checked
// R8 - no low region support makes base read-only
// R9 - base upper bits rw, low bits decode zero
// R10 - unimplemented low bits read back as zero
// R11 - software keeps low region below 4GB
// R12 - software programs base before setting enable
// R13 - software leaves base alone while status set
// R14 - base field is region start physical address
// R15 - limit low bits decode as all ones
// R16 - limit below base disables the low region
// R17 - hit means base <= address <= limit
// R18 - disable stops blocking, then clears status
module pg_guard_dev
  import pg_pkg::*;
#(
  parameter int N_LOW         = 19,
  parameter bit LOW_SUPPORTED = 1'b1,
  parameter bit DRAIN_SUPPORT = 1'b1,
  parameter int MAJOR_VER     = 2
) (
  input  wire logic   sys_clk,
  input  wire logic   srst,
  input  wire logic   ce,
  pg_link_if.dev      lnk,
  input  wire logic   remap_on,
  output logic        guard_active
);

  // ========================================================================
  // decode masks
  // bits above N are implemented, bits N:0 are fixed by the decode
  localparam logic [31:0] IMPL_MASK = 32'hFFFF_FFFF << (N_LOW + 1);
  localparam bit          OLD_VER   = (MAJOR_VER < 2);

  logic        en_r;
  logic [31:0] base_r;
  logic [31:0] limit_r;
  logic [31:0] rdata_r;
  logic        resp_valid_r;
  logic        resp_block_r;
  pg_state_t   state_r;
  pg_state_t   state_nxt;

  logic        wr_en;
  logic        wr_base;
  logic        wr_limit;
  logic [31:0] base_dec;
  logic [31:0] limit_dec;
  logic        region_ok;
  logic        hit;
  logic        checked;
  logic        block_now;
  logic        status;

  // ========================================================================
  // register write decode
  // R8 no-support read-only
  assign wr_en    = lnk.reg_wr && (lnk.reg_addr == PG_PROT_EN_OFF) && LOW_SUPPORTED;
  assign wr_base  = lnk.reg_wr && (lnk.reg_addr == PG_LOW_BASE_OFF) && LOW_SUPPORTED;
  assign wr_limit = lnk.reg_wr && (lnk.reg_addr == PG_LOW_LIMIT_OFF) && LOW_SUPPORTED;

  // enable bit, takes effect on the edge of the write
  // R1 enable bit storage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      en_r <= PG_EN_RST;
    end else if (ce && wr_en) begin
      en_r <= lnk.reg_wdata[PG_EN_BIT];
    end
  end

  // low base: only the implemented upper bits are kept
  // R9 base implemented bits
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      base_r <= PG_LOW_BASE_RST;
    end else if (ce && wr_base) begin
      base_r <= lnk.reg_wdata & IMPL_MASK;
    end
  end

  // low limit: same storage scheme as the base
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      limit_r <= PG_LOW_LIMIT_RST;
    end else if (ce && wr_limit) begin
      limit_r <= lnk.reg_wdata & IMPL_MASK;
    end
  end

  // ========================================================================
  // region decode
  // R14 base is start address
  assign base_dec  = base_r;
  // R15 limit low ones
  assign limit_dec = limit_r | ~IMPL_MASK;
  // R16 inverted limit disables
  assign region_ok = (limit_r >= base_r);
  // R17 inclusive range test
  assign hit = region_ok && (lnk.dma_addr >= base_dec) && (lnk.dma_addr <= limit_dec);

  // which requests go through the check at all
  // older parts let remapped traffic through while remapping is on
  always_comb begin
    case (lnk.dma_kind)
      // R2 io link checked
      PG_REQ_PASS:  checked = 1'b1;
      PG_REQ_REMAP: checked = !(OLD_VER && remap_on);
      // R7 cache link unchecked
      PG_REQ_CACHE: checked = 1'b0;
      // R3 fetch bypass
      PG_REQ_FETCH: checked = 1'b0;
      default:      checked = 1'b1;
    endcase
  end

  // blocking follows the enable bit directly, not the status bit
  // R18 stop blocking first
  assign block_now = en_r && checked && hit;

  // ========================================================================
  // request answer: one cycle after the request, registered
  // a blocked request is only marked blocked; no fault record is produced
  // R4 silent block
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resp_valid_r <= 1'b0;
      resp_block_r <= 1'b0;
    end else if (ce) begin
      resp_valid_r <= lnk.dma_valid;
      // R2 block on hit
      resp_block_r <= lnk.dma_valid && block_now;
    end
  end

  // ========================================================================
  // enable / disable sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PG_ST_OFF: begin
        if (en_r) begin
          state_nxt = DRAIN_SUPPORT ? PG_ST_DRAIN : PG_ST_ON;
        end
      end
      // R6 drain before status
      PG_ST_DRAIN: begin
        if (!en_r) begin
          state_nxt = PG_ST_OFF;
        end else if (lnk.drain_done) begin
          state_nxt = PG_ST_ON;
        end
      end
      PG_ST_ON: begin
        if (!en_r) begin
          state_nxt = PG_ST_STOP;
        end
      end
      // R18 status clears after stop
      PG_ST_STOP: begin
        state_nxt = en_r ? PG_ST_ON : PG_ST_OFF;
      end
      default: begin
        state_nxt = PG_ST_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= PG_ST_OFF;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // status is held through the stop cycle so software never sees it drop early
  // R5 status in force
  assign status = (state_r == PG_ST_ON) || (state_r == PG_ST_STOP);

  // ========================================================================
  // register read, data one cycle after the strobe
  // reserved control bits 30:1 read as zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce && lnk.reg_rd) begin
      case (lnk.reg_addr)
        PG_PROT_EN_OFF: begin
          rdata_r             <= 32'h0000_0000;
          rdata_r[PG_EN_BIT]  <= en_r;
          // R5 status readback
          rdata_r[PG_STS_BIT] <= status;
        end
        // R10 low bits read zero
        PG_LOW_BASE_OFF:  rdata_r <= base_r;
        PG_LOW_LIMIT_OFF: rdata_r <= limit_r;
        default:          rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // outputs
  assign lnk.reg_rdata   = rdata_r;
  assign lnk.resp_valid  = resp_valid_r;
  assign lnk.resp_block  = resp_block_r;
  assign lnk.drain_req   = (state_r == PG_ST_DRAIN);
  assign lnk.prot_status = status;
  assign guard_active    = status;

endmodule

// ### core/pg_guard_host.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
// ==========================================================================
// request path and programming controller end
module pg_guard_host
  import pg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  pg_link_if.host          lnk,
  input  wire logic [7:0]  usr_addr,
  input  wire logic [31:0] usr_wdata,
  input  wire logic        usr_wr,
  input  wire logic        usr_rd,
  output logic      [31:0] usr_rdata
);

  logic [11:0] fwd_addr_r;
  logic [31:0] fwd_data_r;
  logic [31:0] fwd_rdata_r;
  logic        reg_wr_r;
  logic        reg_rd_r;
  logic        rd_wait_r;
  logic        fwd_done_r;
  logic        base_set_r;
  logic        refused_r;
  logic [31:0] dma_addr_r;
  pg_req_t     dma_kind_r;
  logic        dma_pend_r;
  logic        dma_valid_r;
  logic        out_r;
  logic        dma_done_r;
  logic        dma_blk_r;
  logic [31:0] usr_rdata_r;

  logic        cmd_go;
  logic        cmd_wr;
  logic        cmd_rd;
  logic        tgt_region;
  logic        bad_order;
  logic        refuse;
  logic        dma_go;
  logic        dma_issue;

  // ========================================================================
  // forwarded register access with software ordering checks
  assign cmd_go     = ce && usr_wr && (usr_addr == PG_H_FWD_CMD_OFF);
  assign cmd_wr     = usr_wdata[PG_H_CMD_WR_BIT];
  assign cmd_rd     = usr_wdata[PG_H_CMD_RD_BIT] && !cmd_wr;
  assign tgt_region = (fwd_addr_r == PG_LOW_BASE_OFF) || (fwd_addr_r == PG_LOW_LIMIT_OFF);
  // R13 no change while status set
  // R12 base before enable
  assign bad_order  = (tgt_region && lnk.prot_status) ||
                      ((fwd_addr_r == PG_PROT_EN_OFF) && fwd_data_r[PG_EN_BIT] && !base_set_r);
  assign refuse     = cmd_go && cmd_wr && bad_order;

  // address and data staging registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fwd_addr_r <= 12'h000;
      fwd_data_r <= 32'h0000_0000;
    end else if (ce && usr_wr) begin
      if (usr_addr == PG_H_FWD_ADDR_OFF) begin
        fwd_addr_r <= usr_wdata[11:0];
      end
      if (usr_addr == PG_H_FWD_DATA_OFF) begin
        fwd_data_r <= usr_wdata;
      end
    end
  end

  // one-cycle strobes toward the guard, read data caught two edges later
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_wr_r    <= 1'b0;
      reg_rd_r    <= 1'b0;
      rd_wait_r   <= 1'b0;
      fwd_done_r  <= 1'b0;
      fwd_rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      reg_wr_r  <= cmd_go && cmd_wr && !bad_order;
      reg_rd_r  <= cmd_go && cmd_rd;
      rd_wait_r <= reg_rd_r;
      if (cmd_go) begin
        fwd_done_r <= cmd_wr && !bad_order;
      end else if (rd_wait_r) begin
        fwd_done_r <= 1'b1;
      end
      if (rd_wait_r) begin
        fwd_rdata_r <= lnk.reg_rdata;
      end
    end
  end

  // base programmed flag and sticky refusal; a new refusal beats the clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      base_set_r <= 1'b0;
      refused_r  <= 1'b0;
    end else if (ce) begin
      if (cmd_go && cmd_wr && !bad_order && (fwd_addr_r == PG_LOW_BASE_OFF)) begin
        base_set_r <= 1'b1;
      end
      if (refuse) begin
        refused_r <= 1'b1;
      end else if (usr_wr && (usr_addr == PG_H_STATUS_OFF) && usr_wdata[PG_H_ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // memory requests; none issued while the guard asks for a drain
  assign dma_go    = ce && usr_wr && (usr_addr == PG_H_DMA_CMD_OFF);
  assign dma_issue = dma_pend_r && !lnk.drain_req && !out_r && !dma_valid_r;

  // request staging, issue and answer tracking
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dma_addr_r  <= 32'h0000_0000;
      dma_kind_r  <= PG_REQ_PASS;
      dma_pend_r  <= 1'b0;
      dma_valid_r <= 1'b0;
      out_r       <= 1'b0;
      dma_done_r  <= 1'b0;
      dma_blk_r   <= 1'b0;
    end else if (ce) begin
      if (usr_wr && (usr_addr == PG_H_DMA_ADDR_OFF)) begin
        dma_addr_r <= usr_wdata;
      end
      dma_valid_r <= dma_issue;
      if (dma_go && !dma_pend_r) begin
        dma_kind_r <= pg_req_t'(usr_wdata[1:0]);
        dma_pend_r <= 1'b1;
        dma_done_r <= 1'b0;
      end else if (dma_issue) begin
        dma_pend_r <= 1'b0;
      end
      if (dma_issue) begin
        out_r <= 1'b1;
      end else if (lnk.resp_valid) begin
        out_r      <= 1'b0;
        dma_done_r <= 1'b1;
        dma_blk_r  <= lnk.resp_block;
      end
    end
  end

  // ========================================================================
  // user read port, data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      usr_rdata_r <= 32'h0000_0000;
    end else if (ce && usr_rd) begin
      case (usr_addr)
        PG_H_FWD_ADDR_OFF:  usr_rdata_r <= {20'h00000, fwd_addr_r};
        PG_H_FWD_DATA_OFF:  usr_rdata_r <= fwd_data_r;
        PG_H_FWD_RDATA_OFF: usr_rdata_r <= fwd_rdata_r;
        PG_H_DMA_ADDR_OFF:  usr_rdata_r <= dma_addr_r;
        PG_H_STATUS_OFF:    usr_rdata_r <= {26'h0000000, fwd_done_r, dma_pend_r,
                                            lnk.prot_status, refused_r, dma_blk_r, dma_done_r};
        default:            usr_rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign usr_rdata      = usr_rdata_r;
  assign lnk.reg_addr   = fwd_addr_r;
  assign lnk.reg_wdata  = fwd_data_r;
  assign lnk.reg_wr     = reg_wr_r;
  assign lnk.reg_rd     = reg_rd_r;
  assign lnk.dma_valid  = dma_valid_r;
  assign lnk.dma_addr   = dma_addr_r;
  assign lnk.dma_kind   = dma_kind_r;
  // drain granted once nothing is in flight or about to launch
  assign lnk.drain_done = lnk.drain_req && !out_r && !dma_valid_r;

endmodule

// ### dv/pg_guard_props.sv
`timescale 1ns/1ns
// ==========================================================================
// link checks between the guard and its controller
module pg_guard_props
  import pg_pkg::*;
#(
  parameter int N_LOW = 19
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        dma_valid,
  input wire pg_req_t     dma_kind,
  input wire logic        resp_valid,
  input wire logic        resp_block,
  input wire logic        drain_req,
  input wire logic        drain_done,
  input wire logic        prot_status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // control register write decode
  logic en_wr;
  assign en_wr = reg_wr && (reg_addr == PG_PROT_EN_OFF);

  // ========================================================================
  // request path
  a_resp_one_late: assert property (dma_valid |=> resp_valid)
    else $error("no response one cycle after request");
  a_resp_has_req: assert property (resp_valid |-> $past(dma_valid))
    else $error("response without a request");
  a_fetch_passes: assert property (dma_valid && dma_kind == PG_REQ_FETCH |=> !resp_block)
    else $error("structure fetch was blocked");
  a_cache_passes: assert property (dma_valid && dma_kind == PG_REQ_CACHE |=> !resp_block)
    else $error("cache link access was blocked");
  // blocking only while enable is set, so in drain or on
  // a request taken the cycle after the enable write is blocked while the state still reads off
  a_block_when_on: assert property (resp_block |-> resp_valid && (drain_req || prot_status))
    else $error("block while guard off");

  // ========================================================================
  // enable and status sequencing
  a_en_starts_drain: assert property (
    en_wr && reg_wdata[PG_EN_BIT] && !prot_status && !drain_req |=> ##1 drain_req)
    else $error("enable did not start drain");
  a_status_after_drain: assert property ($rose(prot_status) |-> $past(drain_done && drain_req))
    else $error("status set before drain done");
  a_disable_lags: assert property (en_wr && !reg_wdata[PG_EN_BIT] && prot_status
    && $past(prot_status) |=> prot_status ##1 prot_status ##1 !prot_status)
    else $error("status did not fall two cycles after disable");

  // ========================================================================
  // read data
  a_status_reads: assert property (reg_rd && reg_addr == PG_PROT_EN_OFF
    |=> reg_rdata[30:0] == {30'h0, $past(prot_status)})
    else $error("control read mismatch");
  a_base_low_zero: assert property (reg_rd && reg_addr == PG_LOW_BASE_OFF
    |=> reg_rdata[N_LOW:0] == '0)
    else $error("base low bits not zero");

  // main scenarios reached
  c_blocked: cover property (resp_valid && resp_block);
  c_status_on: cover property ($rose(prot_status));
  c_status_off: cover property ($fell(prot_status));
endmodule

// ### dv/tb_dma_protected_region_guard.sv
`timescale 1ns/1ns
// ==========================================================================
// bench: controller and guard joined over the link
module tb_dma_protected_region_guard
  import pg_pkg::*;
;
  localparam int          NL   = 19;
  localparam logic [31:0] LOW1 = (32'h1 << (NL + 1)) - 32'h1;
  localparam logic [31:0] BASE = 32'h0040_0000;
  localparam logic [31:0] ENB  = 32'h8000_0000;

  logic        sys_clk   = 1'b0;
  logic        srst      = 1'b1;
  logic [7:0]  usr_addr  = 8'h00;
  logic [31:0] usr_wdata = 32'h0;
  logic        usr_wr    = 1'b0;
  logic        usr_rd    = 1'b0;
  logic        remap_on  = 1'b1;
  logic [31:0] usr_rdata;
  logic        guard_active;
  int          fail_count = 0;
  int          checks     = 0;
  int          cycles     = 0;

  pg_link_if lnk ();

  // remap_on is dropped once: newer guards block regardless of remapping
  pg_guard_dev #(.N_LOW(NL)) pg_guard_dev_inst (
    .sys_clk(sys_clk), .srst(srst), .ce(1'b1), .lnk(lnk),
    .remap_on(remap_on), .guard_active(guard_active));
  pg_guard_host pg_guard_host_inst (
    .sys_clk(sys_clk), .srst(srst), .ce(1'b1), .lnk(lnk), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata));
  pg_guard_props #(.N_LOW(NL)) pg_guard_props_inst (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata),
    .dma_valid(lnk.dma_valid), .dma_kind(lnk.dma_kind), .resp_valid(lnk.resp_valid),
    .resp_block(lnk.resp_block), .drain_req(lnk.drain_req), .drain_done(lnk.drain_done),
    .prot_status(lnk.prot_status));

  // clock and hang guard; the run needs a few hundred cycles
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  // ========================================================================
  // report and compare
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ========================================================================
  // user port cycles
  task automatic uw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    usr_addr <= a;
    usr_wdata <= d;
    usr_wr <= 1'b1;
    @(posedge sys_clk);
    usr_wr <= 1'b0;
  endtask

  task automatic ur(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    usr_addr <= a;
    usr_rd <= 1'b1;
    @(posedge sys_clk);
    usr_rd <= 1'b0;
    #1 d = usr_rdata;
  endtask

  // forwarded device accesses settle within three edges of the command
  task automatic dev_wr(input logic [11:0] a, input logic [31:0] d);
    uw(PG_H_FWD_ADDR_OFF, {20'h0, a});
    uw(PG_H_FWD_DATA_OFF, d);
    uw(PG_H_FWD_CMD_OFF, 32'h1);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic dev_chk(input logic [11:0] a, input logic [31:0] exp, input string n);
    logic [31:0] d;
    uw(PG_H_FWD_ADDR_OFF, {20'h0, a});
    uw(PG_H_FWD_CMD_OFF, 32'h2);
    repeat (4) @(posedge sys_clk);
    ur(PG_H_FWD_RDATA_OFF, d);
    chk(n, exp, d);
  endtask

  // one request, then done and blocked flags from the status word
  task automatic dma(input logic [31:0] a, input int k, input logic b);
    logic [31:0] s;
    uw(PG_H_DMA_ADDR_OFF, a);
    uw(PG_H_DMA_CMD_OFF, k);
    repeat (4) @(posedge sys_clk);
    ur(PG_H_STATUS_OFF, s);
    chk("dma flags", {30'h0, b, 1'b1}, {30'h0, s[1:0]});
  endtask

  task automatic refused(input logic v);
    logic [31:0] s;
    ur(PG_H_STATUS_OFF, s);
    chk("refused", {31'h0, v}, {31'h0, s[PG_H_ST_REFUSED]});
    uw(PG_H_STATUS_OFF, 32'h4);
  endtask

  task automatic wait_guard(input logic v);
    logic [31:0] s;
    for (int i = 0; i < 30; i++) begin
      ur(PG_H_STATUS_OFF, s);
      if (s[PG_H_ST_GUARD] === v) break;
    end
    chk("guard bit", {31'h0, v}, {31'h0, s[PG_H_ST_GUARD]});
    chk("guard port", {31'h0, v}, {31'h0, guard_active});
  endtask

  // ========================================================================
  // scenarios
  task automatic t_reset();
    dev_chk(PG_PROT_EN_OFF, 32'h0, "ctrl reset");
    dev_chk(PG_LOW_BASE_OFF, 32'h0, "base reset");
    dev_wr(PG_PROT_EN_OFF, ENB);
    refused(1'b1);
    wait_guard(1'b0);
  endtask

  task automatic t_align();
    dev_wr(PG_LOW_BASE_OFF, 32'hFFFF_FFFF);
    dev_chk(PG_LOW_BASE_OFF, ~LOW1, "base ones");
    dev_wr(PG_LOW_LIMIT_OFF, 32'hFFFF_FFFF);
    dev_chk(PG_LOW_LIMIT_OFF, ~LOW1, "limit ones");
  endtask

  // region of one aligned block at BASE, probed at both edges
  task automatic t_hits();
    logic [31:0] ad [4] = '{BASE - 32'h4, BASE, BASE | LOW1, BASE + LOW1 + 32'h1};
    dev_wr(PG_LOW_BASE_OFF, BASE);
    dev_wr(PG_LOW_LIMIT_OFF, BASE);
    dev_wr(PG_PROT_EN_OFF, ENB);
    wait_guard(1'b1);
    dev_chk(PG_PROT_EN_OFF, 32'h8000_0001, "ctrl on");
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        dma(ad[i], k, (i == 1 || i == 2) && k < 2);
      end
    end
    // remapped traffic is still blocked with remapping turned off
    @(posedge sys_clk);
    remap_on <= 1'b0;
    dma(BASE, 1, 1'b1);
    @(posedge sys_clk);
    remap_on <= 1'b1;
    dev_wr(PG_LOW_BASE_OFF, 32'h0);
    refused(1'b1);
    dev_chk(PG_LOW_BASE_OFF, BASE, "base kept");
  endtask

  // disable, then a limit below base leaves nothing protected
  task automatic t_off();
    dev_wr(PG_PROT_EN_OFF, 32'h0);
    wait_guard(1'b0);
    dma(BASE, 0, 1'b0);
    dev_wr(PG_LOW_LIMIT_OFF, BASE - LOW1 - 32'h1);
    dev_wr(PG_PROT_EN_OFF, ENB);
    wait_guard(1'b1);
    dma(BASE, 0, 1'b0);
    dma(BASE - 32'h4, 1, 1'b0);
    dev_wr(PG_PROT_EN_OFF, 32'h0);
    wait_guard(1'b0);
  endtask

  // main sequence after the reset hold
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_align();
    t_hits();
    t_off();
    complete_run();
  end
endmodule
